// File: rtl/mstd_top.v
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "mstd_defines.vh"
//////////////////////////////////////////////////////////////////////////////
module mstd_top #(
   parameter [`MSTD_TW-1:0] VOLT_CYC = (`MSTD_T_VOLT_NS * `MSTD_CLK_MHZ + 999) / 1000,
   parameter [`MSTD_TW-1:0] TEMP_CYC = (`MSTD_T_TEMP_NS * `MSTD_CLK_MHZ + 999) / 1000,
   parameter [`MSTD_TW-1:0] PU_TEMP_CYC = (`MSTD_T_PU_TEMP_NS * `MSTD_CLK_MHZ + 999) / 1000,
   parameter [`MSTD_TW-1:0] PU_WAKE_CYC = (`MSTD_T_PU_WAKE_NS * `MSTD_CLK_MHZ + 999) / 1000,
   parameter [`MSTD_TW-1:0] CYC_PER_US = `MSTD_CYC_PER_US
) (
   input wire SYS_CLK,
   input wire RST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [`MSTD_AW-1:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   input wire [`MSTD_DW-1:0] ADC_DATA,
   output reg ADC_START,
   output reg [3:0] ADC_CHAN,
   output reg ADC_TEMP,
   output reg ADC_DIFF,
   output reg REF_ON,
   output reg SHUTDOWN,
   output reg BUSY
);
   localparam NCH = `MSTD_NCH;
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_PWRUP = 3'h1;
   localparam [2:0] S_CONV = 3'h2;
   localparam [2:0] S_WAIT = 3'h3;
   localparam [2:0] S_WAKE = 3'h4;

   // register file
   reg [7:0] setup_reg;
   reg [9:0] chen_reg;
   reg [11:0] incfg_reg;
   reg [23:0] alarm_reg;
   reg [`MSTD_DW-1:0] data_reg [0:NCH-1];
   reg [`MSTD_DW-1:0] upper_reg [0:NCH-1];
   reg [`MSTD_DW-1:0] lower_reg [0:NCH-1];
   reg [7:0] ccfg_reg [0:NCH-1];
   reg [2:0] fcnt_reg [0:NCH-1];
   // sequencer
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [3:0] idx_reg;
   reg [3:0] idx_next;
   reg manual_reg;
   reg manual_next;
   reg tmr_ld;
   reg [`MSTD_TW-1:0] tmr_val;
   reg start_next;
   reg cap;
   reg sel_go;
   reg [3:0] sel_slot;
   reg [4:0] first_slot;
   reg [4:0] after_slot;
   wire tmr_done;
   // bus side
   reg [31:0] rd_val;
   reg rd_ok;
   reg [`MSTD_DW-1:0] sample;
   reg out_hi;
   reg out_lo;
   integer i;

   wire scan_en = setup_reg[`MSTD_SETUP_SCAN];
   wire [1:0] ref_mode = setup_reg[`MSTD_SETUP_REF_LO+1:`MSTD_SETUP_REF_LO];
   wire [2:0] wait_code = setup_reg[`MSTD_SETUP_WAIT_LO+2:`MSTD_SETUP_WAIT_LO];
   wire [3:0] pair_diff = incfg_reg[`MSTD_INCFG_DIFF_LO+3:`MSTD_INCFG_DIFF_LO];
   wire wr_en = PSEL && PENABLE && PWRITE && PREADY;
   wire do_srst = wr_en && (PADDR == `MSTD_A_CMD) && PWDATA[`MSTD_CMD_RESET];
   wire do_conv = wr_en && (PADDR == `MSTD_A_CMD) && PWDATA[`MSTD_CMD_CONV];

   //////////////////////////////////////////////////////////////////////////
   // decode helpers

   // hit in a per-channel block of word registers
   function region_hit(input [`MSTD_AW-1:0] a, input [`MSTD_AW-1:0] base);
      begin
         region_hit = (a[`MSTD_AW-1:6] == base[`MSTD_AW-1:6]) && (a[5:2] < NCH)
            && (a[1:0] == 2'h0);
      end
   endfunction

   // wait length in microseconds for a setup code
   function [10:0] wait_us(input [2:0] c);
      begin
         case (c)
            3'h0: wait_us = `MSTD_WAIT0_US;
            3'h1: wait_us = `MSTD_WAIT1_US;
            3'h2: wait_us = `MSTD_WAIT2_US;
            3'h3: wait_us = `MSTD_WAIT3_US;
            3'h4: wait_us = `MSTD_WAIT4_US;
            3'h5: wait_us = `MSTD_WAIT5_US;
            3'h6: wait_us = `MSTD_WAIT6_US;
            default: wait_us = `MSTD_WAIT7_US;
         endcase
      end
   endfunction

   // odd input of a differential pair is folded into its even slot
   function slot_on(input [3:0] s);
      begin
         if (s < 4'h8 && s[0] && pair_diff[s[2:1]])
            slot_on = 1'b0;
         else
            slot_on = chen_reg[s];
      end
   endfunction

   // slot 8 is the on-chip sensor, slot 9 the supply monitor
   function slot_temp(input [3:0] s);
      begin
         if (s == 4'h8)
            slot_temp = 1'b1;
         else if (s == 4'h9)
            slot_temp = 1'b0;
         else
            slot_temp = incfg_reg[s[2:0]];
      end
   endfunction

   function slot_diff(input [3:0] s);
      begin
         slot_diff = (s < 4'h8) && pair_diff[s[2:1]];
      end
   endfunction

   // first enabled slot at or after from, {found, index}
   function [4:0] next_slot(input [4:0] from);
      integer k;
      begin
         next_slot = 5'h00;
         for (k = NCH - 1; k >= 0; k = k - 1) begin
            if (k >= from && slot_on(k[3:0]))
               next_slot = {1'b1, k[3:0]};
         end
      end
   endfunction

   wire [31:0] wait_prod = wait_us(wait_code) * CYC_PER_US;
   wire [`MSTD_TW-1:0] wait_cyc = wait_prod[`MSTD_TW-1:0];
   wire long_wait = wait_us(wait_code) > `MSTD_WAKE_MIN_US;
   wire auto_sd = (ref_mode == `MSTD_REF_PU_TEMP)
      || (ref_mode == `MSTD_REF_PU_WAKE && long_wait);

   //////////////////////////////////////////////////////////////////////////
   // interval timer on the system clock
   mstd_timer u_timer (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .load(tmr_ld),
      .load_val(tmr_val),
      .done(tmr_done)
   );

   //////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always @* begin
      state_next = state_reg;
      idx_next = idx_reg;
      manual_next = manual_reg;
      tmr_ld = 1'b0;
      tmr_val = {`MSTD_TW{1'b0}};
      start_next = 1'b0;
      cap = 1'b0;
      sel_go = 1'b0;
      sel_slot = 4'h0;
      first_slot = next_slot(5'h00);
      after_slot = next_slot({1'b0, idx_reg} + 5'h01);
      case (state_reg)
         S_IDLE: begin
            if (scan_en && first_slot[4]) begin
               sel_go = 1'b1;
               sel_slot = first_slot[3:0];
               manual_next = 1'b0;
            end else if (do_conv && !scan_en
                  && slot_on(PWDATA[`MSTD_CMD_CHAN_LO+3:`MSTD_CMD_CHAN_LO])) begin
               sel_go = 1'b1;
               sel_slot = PWDATA[`MSTD_CMD_CHAN_LO+3:`MSTD_CMD_CHAN_LO];
               manual_next = 1'b1;
            end
         end
         S_PWRUP: begin
            if (tmr_done) begin
               state_next = S_CONV;
               tmr_ld = 1'b1;
               tmr_val = slot_temp(idx_reg) ? TEMP_CYC : VOLT_CYC;
               start_next = 1'b1;
            end
         end
         S_CONV: begin
            if (tmr_done) begin
               cap = 1'b1;
               if (manual_reg || !scan_en) begin
                  state_next = S_IDLE;
               end else if (after_slot[4]) begin
                  sel_go = 1'b1;
                  sel_slot = after_slot[3:0];
               end else if (wait_cyc != {`MSTD_TW{1'b0}}) begin
                  state_next = S_WAIT;
                  tmr_ld = 1'b1;
                  tmr_val = wait_cyc;
               end else begin
                  sel_go = first_slot[4];
                  sel_slot = first_slot[3:0];
               end
            end
         end
         S_WAIT: begin
            if (tmr_done && scan_en) begin
               if (ref_mode == `MSTD_REF_PU_WAKE && long_wait) begin
                  state_next = S_WAKE;
                  tmr_ld = 1'b1;
                  tmr_val = PU_WAKE_CYC;
               end else begin
                  sel_go = first_slot[4];
                  sel_slot = first_slot[3:0];
               end
            end
         end
         S_WAKE: begin
            if (tmr_done && scan_en) begin
               sel_go = first_slot[4];
               sel_slot = first_slot[3:0];
            end
         end
         default: state_next = S_IDLE;
      endcase
      // start of one slot, with power-up ahead of a temperature slot
      if (sel_go) begin
         idx_next = sel_slot;
         tmr_ld = 1'b1;
         if (slot_temp(sel_slot) && ref_mode == `MSTD_REF_PU_TEMP) begin
            state_next = S_PWRUP;
            tmr_val = PU_TEMP_CYC;
         end else begin
            state_next = S_CONV;
            tmr_val = slot_temp(sel_slot) ? TEMP_CYC : VOLT_CYC;
            start_next = 1'b1;
         end
      end else if ((state_reg == S_CONV || state_reg == S_WAIT || state_reg == S_WAKE)
            && tmr_done && !tmr_ld) begin
         state_next = S_IDLE;
      end
      if (do_srst) begin
         state_next = S_IDLE;
         start_next = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // sequencer state and converter strobes
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= S_IDLE;
         idx_reg <= 4'h0;
         manual_reg <= 1'b0;
         ADC_START <= 1'b0;
         ADC_CHAN <= 4'h0;
         ADC_TEMP <= 1'b0;
         ADC_DIFF <= 1'b0;
         REF_ON <= 1'b0;
         SHUTDOWN <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         manual_reg <= manual_next;
         ADC_START <= start_next;
         if (start_next) begin
            ADC_CHAN <= idx_next;
            ADC_TEMP <= slot_temp(idx_next);
            ADC_DIFF <= slot_diff(idx_next);
         end
         SHUTDOWN <= (state_next == S_WAIT) && auto_sd;
         REF_ON <= (state_next != S_IDLE) && !((state_next == S_WAIT) && auto_sd);
         BUSY <= (state_next != S_IDLE);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // result shaping and limit check
   always @* begin
      if (slot_temp(idx_reg))
         sample = {{(`MSTD_DW-10){ADC_DATA[9]}}, ADC_DATA[9:0]};
      else
         sample = ADC_DATA;
      out_hi = sample > upper_reg[idx_reg];
      out_lo = sample < lower_reg[idx_reg];
   end

   //////////////////////////////////////////////////////////////////////////
   // register file: bus writes, captures, power-on and command reset
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         setup_reg <= `MSTD_RST_SETUP;
         chen_reg <= `MSTD_RST_CHEN;
         incfg_reg <= `MSTD_RST_INCFG;
         alarm_reg <= `MSTD_RST_ALARM;
         for (i = 0; i < NCH; i = i + 1) begin
            data_reg[i] <= `MSTD_RST_DATA;
            upper_reg[i] <= `MSTD_RST_UPPER;
            lower_reg[i] <= `MSTD_RST_LOWER;
            ccfg_reg[i] <= `MSTD_RST_CCFG;
            fcnt_reg[i] <= 3'h0;
         end
      end else if (do_srst) begin
         setup_reg <= `MSTD_RST_SETUP;
         chen_reg <= `MSTD_RST_CHEN;
         incfg_reg <= `MSTD_RST_INCFG;
         alarm_reg <= `MSTD_RST_ALARM;
         for (i = 0; i < NCH; i = i + 1) begin
            data_reg[i] <= `MSTD_RST_DATA;
            upper_reg[i] <= `MSTD_RST_UPPER;
            lower_reg[i] <= `MSTD_RST_LOWER;
            ccfg_reg[i] <= `MSTD_RST_CCFG;
            fcnt_reg[i] <= 3'h0;
         end
      end else begin
         if (wr_en) begin
            if (PADDR == `MSTD_A_SETUP)
               setup_reg <= PWDATA[7:0];
            if (PADDR == `MSTD_A_CHEN)
               chen_reg <= PWDATA[9:0];
            if (PADDR == `MSTD_A_INCFG)
               incfg_reg <= PWDATA[11:0];
            if (region_hit(PADDR, `MSTD_A_UPPER))
               upper_reg[PADDR[5:2]] <= PWDATA[`MSTD_DW-1:0];
            if (region_hit(PADDR, `MSTD_A_LOWER))
               lower_reg[PADDR[5:2]] <= PWDATA[`MSTD_DW-1:0];
            if (region_hit(PADDR, `MSTD_A_CCFG))
               ccfg_reg[PADDR[5:2]] <= PWDATA[7:0];
         end
         // store result, count consecutive faults, raise sticky alarm
         if (cap) begin
            data_reg[idx_reg] <= sample;
            if (out_hi || out_lo) begin
               if (fcnt_reg[idx_reg] != 3'h7)
                  fcnt_reg[idx_reg] <= fcnt_reg[idx_reg] + 3'h1;
               if (fcnt_reg[idx_reg] >= ccfg_reg[idx_reg][`MSTD_CCFG_FAULT_LO+2:0]) begin
                  if (out_hi)
                     alarm_reg[{idx_reg, 1'b1}] <= 1'b1;
                  if (out_lo)
                     alarm_reg[{idx_reg, 1'b0}] <= 1'b1;
               end
            end else begin
               fcnt_reg[idx_reg] <= 3'h0;
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read mux
   always @* begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      if (PADDR == `MSTD_A_SETUP)
         rd_val = {24'h000000, setup_reg};
      else if (PADDR == `MSTD_A_CHEN)
         rd_val = {22'h000000, chen_reg};
      else if (PADDR == `MSTD_A_INCFG)
         rd_val = {20'h00000, incfg_reg};
      else if (PADDR == `MSTD_A_ALARM)
         rd_val = {8'h00, alarm_reg};
      else if (PADDR == `MSTD_A_CMD)
         rd_val = 32'h00000000;
      else if (PADDR == `MSTD_A_STATUS)
         rd_val = {22'h000000, state_reg, idx_reg, manual_reg, SHUTDOWN, BUSY};
      else if (region_hit(PADDR, `MSTD_A_DATA))
         rd_val = {20'h00000, data_reg[PADDR[5:2]]};
      else if (region_hit(PADDR, `MSTD_A_UPPER))
         rd_val = {20'h00000, upper_reg[PADDR[5:2]]};
      else if (region_hit(PADDR, `MSTD_A_LOWER))
         rd_val = {20'h00000, lower_reg[PADDR[5:2]]};
      else if (region_hit(PADDR, `MSTD_A_CCFG))
         rd_val = {24'h000000, ccfg_reg[PADDR[5:2]]};
      else
         rd_ok = 1'b0;
   end

   //////////////////////////////////////////////////////////////////////////
   // apb answer one cycle into the access phase
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && PENABLE && !PREADY;
         if (PSEL && PENABLE && !PREADY) begin
            PRDATA <= PWRITE ? 32'h00000000 : rd_val;
            PSLVERR <= !rd_ok;
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end
endmodule // mstd_top

// File: inc/mstd_defines.vh
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - reset clears whole alarm register to zero
// - reset loads every result register with midscale
// - reset sets every upper limit to ones
// - reset clears every lower limit to zero
// - reset clears per-channel settings to zero
// - voltage 10.6 us, temperature 46 us conversions
// - differential pair converts as one scan slot
// - setting 00: 20 us power-up before temperature
// - setting 01: 40 us wake after long wait
// - setting 10: no reference power-up at all
// - scan period sums power-up, conversions, wait
// - setup top three bits select wait time
// - conversions timed by on-chip clock only
// - shutdown between scans in 00, long-wait 01
// - temperature single-ended or differential pair inputs
// - pairs 0/1..6/7, even anode, odd cathode
// - temperature is 10-bit two's complement, half degree
// - reset clears setup register to zero
//////////////////////////////////////////////////////////////////////////////
`ifndef MSTD_DEFINES_VH
`define MSTD_DEFINES_VH

// widths
`define MSTD_AW 12
`define MSTD_DW 12
`define MSTD_TW 24
`define MSTD_NCH 10

// timing
`define MSTD_CLK_MHZ 250
`define MSTD_T_VOLT_NS 10600
`define MSTD_T_TEMP_NS 46000
`define MSTD_T_PU_TEMP_NS 20000
`define MSTD_T_PU_WAKE_NS 40000
`define MSTD_WAKE_MIN_US 80
`define MSTD_CYC_PER_US 250

// wait time per setup code, in microseconds
`define MSTD_WAIT0_US 0
`define MSTD_WAIT1_US 20
`define MSTD_WAIT2_US 40
`define MSTD_WAIT3_US 80
`define MSTD_WAIT4_US 160
`define MSTD_WAIT5_US 395
`define MSTD_WAIT6_US 790
`define MSTD_WAIT7_US 1580

// register byte offsets
`define MSTD_A_SETUP 12'h000
`define MSTD_A_CHEN 12'h004
`define MSTD_A_INCFG 12'h008
`define MSTD_A_ALARM 12'h00C
`define MSTD_A_CMD 12'h010
`define MSTD_A_STATUS 12'h014
`define MSTD_A_DATA 12'h040
`define MSTD_A_UPPER 12'h080
`define MSTD_A_LOWER 12'h0C0
`define MSTD_A_CCFG 12'h100

// setup fields
`define MSTD_SETUP_SCAN 0
`define MSTD_SETUP_REF_LO 1
`define MSTD_SETUP_WAIT_LO 5
`define MSTD_REF_PU_TEMP 2'h0
`define MSTD_REF_PU_WAKE 2'h1

// input configuration fields: temperature bits 7:0, differential pairs 11:8
`define MSTD_INCFG_DIFF_LO 8

// command fields
`define MSTD_CMD_RESET 0
`define MSTD_CMD_CONV 1
`define MSTD_CMD_CHAN_LO 4

// channel configuration: allowed faults
`define MSTD_CCFG_FAULT_LO 0

// reset values
`define MSTD_RST_SETUP 8'h00
`define MSTD_RST_CHEN 10'h3FF
`define MSTD_RST_INCFG 12'h000
`define MSTD_RST_ALARM 24'h000000
`define MSTD_RST_DATA 12'h800
`define MSTD_RST_UPPER 12'hFFF
`define MSTD_RST_LOWER 12'h000
`define MSTD_RST_CCFG 8'h00

`endif

// File: rtl/mstd_timer.v
`timescale 1ns/1ns
`include "mstd_defines.vh"
//////////////////////////////////////////////////////////////////////////////
// down counter: done pulses in the last cycle of a loaded interval
module mstd_timer (
   input wire clk,
   input wire rst_n,
   input wire load,
   input wire [`MSTD_TW-1:0] load_val,
   output wire done
);
   reg [`MSTD_TW-1:0] cnt_reg;
   reg run_reg;

   // interval of load_val cycles counts from the load edge on
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= {`MSTD_TW{1'b0}};
         run_reg <= 1'b0;
      end else if (load) begin
         cnt_reg <= load_val;
         run_reg <= (load_val != {`MSTD_TW{1'b0}});
      end else if (run_reg) begin
         cnt_reg <= cnt_reg - 1'b1;
         run_reg <= (cnt_reg != {{(`MSTD_TW-1){1'b0}}, 1'b1});
      end
   end

   assign done = run_reg && (cnt_reg == {{(`MSTD_TW-1){1'b0}}, 1'b1});
endmodule // mstd_timer

// File: dv/mstd_adc_model.sv
`timescale 1ns/1ns
`include "mstd_defines.vh"
// converter front end: the result is valid only in the sampling cycle
module mstd_adc_model #(
   parameter VOLT_CYC = 5,
   parameter TEMP_CYC = 9
) (
   input wire clk,
   input wire rst_n,
   input wire start,
   input wire [3:0] chan,
   input wire temp,
   output wire [`MSTD_DW-1:0] data
);
   reg [15:0] cnt_reg;
   reg temp_reg;
   reg [3:0] chan_reg;
   wire [15:0] phase = start ? 16'h0000 : cnt_reg;
   wire is_temp = start ? temp : temp_reg;
   wire [3:0] ch = start ? chan : chan_reg;
   wire [15:0] last = is_temp ? 16'(TEMP_CYC - 1) : 16'(VOLT_CYC - 1);
   wire [11:0] val = 12'h7C0 | {8'h00, ch};
   // inverse value outside the sampling cycle, so a stray sample shows
   assign data = (phase == last) ? val : ~val;
   // cycles since the last start
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
         temp_reg <= 1'b0;
         chan_reg <= 4'h0;
      end else begin
         cnt_reg <= phase + 16'h0001;
         temp_reg <= is_temp;
         chan_reg <= ch;
      end
   end
endmodule // mstd_adc_model

// File: dv/mstd_top_properties.sv
`timescale 1ns/1ns
`include "mstd_defines.vh"
module mstd_checker #(
   parameter [`MSTD_TW-1:0] VOLT_CYC = 5,
   parameter [`MSTD_TW-1:0] TEMP_CYC = 9
) (
   input wire SYS_CLK,
   input wire RST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire ADC_START,
   input wire [3:0] ADC_CHAN,
   input wire ADC_TEMP,
   input wire ADC_DIFF,
   input wire REF_ON,
   input wire SHUTDOWN,
   input wire BUSY
);
   reg [`MSTD_TW-1:0] gap_reg;
   reg tmp_reg;
   reg seen_reg;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////
   // cycles since the last conversion start, saturating
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         gap_reg <= 24'h000000;
         tmp_reg <= 1'b0;
         seen_reg <= 1'b0;
      end else if (ADC_START) begin
         gap_reg <= 24'h000001;
         tmp_reg <= ADC_TEMP;
         seen_reg <= 1'b1;
      end else if (gap_reg != 24'hFFFFFF) begin
         gap_reg <= gap_reg + 24'h000001;
      end
   end
   // bus and sequencer steps
   sequence apb_access;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence next_start;
      ADC_START && seen_reg;
   endsequence
   apb_wait_a: assert property (apb_access |=> PREADY)
      else $error("no ready after access phase");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
      else $error("error without ready");
   write_zero_a: assert property (PREADY && PWRITE |-> PRDATA == 32'h00000000)
      else $error("read data not zero on write");
   conv_time_a: assert property (next_start |-> gap_reg >= (tmp_reg ? TEMP_CYC : VOLT_CYC))
      else $error("conversion cut short");
   start_busy_a: assert property (ADC_START |-> BUSY && REF_ON ##1 !ADC_START)
      else $error("start while idle or too long");
   diff_pair_a: assert property (ADC_START && ADC_DIFF |-> ADC_CHAN < 4'h8 && !ADC_CHAN[0])
      else $error("pair slot not even");
   chan_range_a: assert property (ADC_START |-> ADC_CHAN <= 4'h9 && (ADC_CHAN != 4'h8 || ADC_TEMP))
      else $error("bad slot");
   sleep_a: assert property (SHUTDOWN |-> BUSY && !REF_ON && !ADC_START)
      else $error("shutdown outside wait");
endmodule // mstd_checker

bind mstd_top mstd_checker #(.VOLT_CYC(VOLT_CYC), .TEMP_CYC(TEMP_CYC)) chk (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ADC_START(ADC_START),
   .ADC_CHAN(ADC_CHAN), .ADC_TEMP(ADC_TEMP), .ADC_DIFF(ADC_DIFF), .REF_ON(REF_ON),
   .SHUTDOWN(SHUTDOWN), .BUSY(BUSY));

// File: dv/mstd_tb.sv
`timescale 1ns/1ns
`include "mstd_defines.vh"
module mstd_tb;
   reg SYS_CLK = 1'b0;
   reg RST_N = 1'b0;
   reg PSEL = 1'b0;
   reg PENABLE = 1'b0;
   reg PWRITE = 1'b0;
   reg [11:0] PADDR = 12'h000;
   reg [31:0] PWDATA = 32'h00000000;
   wire [31:0] PRDATA;
   wire PREADY, PSLVERR, ADC_START, ADC_TEMP, ADC_DIFF, REF_ON, SHUTDOWN, BUSY;
   wire [11:0] ADC_DATA;
   wire [3:0] ADC_CHAN;
   integer fail_count = 0;
   integer cmp_count = 0;
   integer i, k, n;
   reg sd_seen = 1'b0;
   reg [31:0] rd;
   reg er;
   wire [31:0] slot = {26'h0, ADC_CHAN, ADC_TEMP, ADC_DIFF};
   // reset value rows: address, expected word, 12'h200 is unmapped
   reg [11:0] r_addr [0:10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h040, 12'h064,
      12'h080, 12'h0A4, 12'h0D4, 12'h10C, 12'h200};
   reg [31:0] r_exp [0:10] = '{32'h0, 32'h3FF, 32'h0, 32'h0, 32'h800, 32'h800,
      32'hFFF, 32'hFFF, 32'h0, 32'h0, 32'h0};
   // scan rows: setup word, three start gaps, shutdown expected
   reg [31:0] s_setup [0:3] = '{32'h25, 32'h21, 32'h83, 32'h63};
   integer s_gap [0:11] = '{9, 9, 25, 13, 9, 29, 9, 9, 171, 9, 9, 85};
   reg [31:0] s_sd [0:3] = '{0, 1, 1, 0};
   reg [31:0] e_slot [0:2] = '{32'h03, 32'h0A, 32'h24};

   always #2 SYS_CLK = ~SYS_CLK;
   // shutdown watch
   always @(negedge SYS_CLK) if (SHUTDOWN === 1'b1) sd_seen = 1'b1;

   mstd_top #(.VOLT_CYC(5), .TEMP_CYC(9), .PU_TEMP_CYC(4), .PU_WAKE_CYC(6),
      .CYC_PER_US(1)) uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ADC_DATA(ADC_DATA),
      .ADC_START(ADC_START), .ADC_CHAN(ADC_CHAN), .ADC_TEMP(ADC_TEMP),
      .ADC_DIFF(ADC_DIFF), .REF_ON(REF_ON), .SHUTDOWN(SHUTDOWN), .BUSY(BUSY));
   mstd_adc_model adc (.clk(SYS_CLK), .rst_n(RST_N),
      .start(ADC_START), .chan(ADC_CHAN), .temp(ADC_TEMP), .data(ADC_DATA));

   ////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task tmo;
      fail_count = fail_count + 1;
      $display("wrong value at %0t: wait ran out", $time);
      wrap_up;
   endtask
   task chk_val(input [31:0] got, input [31:0] exp, input string msg);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task chk_cnt(input integer got, input integer exp, input string msg);
      cmp_count = cmp_count + 1;
      if (got != exp) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask
   // one bus transfer, held until ready is sampled
   task apb(input w, input [11:0] a, input [31:0] d);
      integer m;
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      m = 0;
      do begin
         @(posedge SYS_CLK);
         m = m + 1;
      end while (PREADY !== 1'b1 && m < 20);
      if (PREADY !== 1'b1) tmo;
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // cycles until the next conversion start
   task wait_start;
      n = 0;
      do begin
         @(negedge SYS_CLK);
         n = n + 1;
      end while (ADC_START !== 1'b1 && n < 400);
      if (ADC_START !== 1'b1) tmo;
   endtask
   task wait_idle;
      n = 0;
      while (BUSY !== 1'b0 && n < 600) begin
         @(negedge SYS_CLK);
         n = n + 1;
      end
      if (BUSY !== 1'b0) tmo;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      for (i = 0; i < 11; i = i + 1) begin
         apb(1'b0, r_addr[i], 32'h0);
         chk_val({31'h0, er}, {31'h0, r_addr[i] == 12'h200}, "error flag");
         chk_val(rd, r_exp[i], "reset value");
      end
      $display("test reset table done");
      apb(1'b1, `MSTD_A_CMD, 32'h32);
      wait_start;
      chk_val(slot, 32'h0C, "manual slot");
      wait_idle;
      apb(1'b0, `MSTD_A_DATA + 12'h00C, 32'h0);
      chk_val(rd, 32'h7C3, "voltage result");
      $display("test manual done");
      apb(1'b1, `MSTD_A_CHEN, 32'h207);
      apb(1'b1, `MSTD_A_INCFG, 32'h105);
      apb(1'b1, `MSTD_A_UPPER + 12'h024, 32'h100);
      for (i = 0; i < 4; i = i + 1) begin
         apb(1'b1, `MSTD_A_SETUP, s_setup[i]);
         sd_seen = 1'b0;
         wait_start;
         chk_val(slot, e_slot[0], "first slot");
         for (k = 0; k < 3; k = k + 1) begin
            wait_start;
            chk_cnt(n, s_gap[3 * i + k], "start gap");
            chk_val(slot, e_slot[(k + 1) % 3], "slot order");
         end
         apb(1'b1, `MSTD_A_SETUP, 32'h0);
         wait_idle;
         chk_val({31'h0, sd_seen}, s_sd[i], "shutdown seen");
      end
      $display("test scan timing done");
      apb(1'b0, `MSTD_A_DATA, 32'h0);
      chk_val(rd, 32'hFC0, "pair result");
      apb(1'b0, `MSTD_A_DATA + 12'h004, 32'h0);
      chk_val(rd, 32'h800, "odd input skipped");
      apb(1'b0, `MSTD_A_DATA + 12'h024, 32'h0);
      chk_val(rd, 32'h7C9, "supply result");
      apb(1'b0, `MSTD_A_ALARM, 32'h0);
      chk_val(rd, 32'h80000, "alarm word");
      $display("test results done");
      apb(1'b1, `MSTD_A_CMD, 32'h1);
      apb(1'b0, `MSTD_A_ALARM, 32'h0);
      chk_val(rd, 32'h0, "alarm after command");
      apb(1'b0, `MSTD_A_UPPER + 12'h024, 32'h0);
      chk_val(rd, 32'hFFF, "upper after command");
      apb(1'b0, `MSTD_A_DATA, 32'h0);
      chk_val(rd, 32'h800, "data after command");
      apb(1'b0, `MSTD_A_INCFG, 32'h0);
      chk_val(rd, 32'h0, "input cfg after command");
      $display("test reset command done");
      apb(1'b1, 12'h200, 32'h5);
      chk_val({31'h0, er}, 32'h1, "unmapped write");
      apb(1'b1, `MSTD_A_DATA, 32'h123);
      apb(1'b0, `MSTD_A_DATA, 32'h0);
      chk_val(rd, 32'h800, "read-only data");
      $display("test refusals done");
      apb(1'b1, `MSTD_A_LOWER + 12'h020, 32'hFFF);
      apb(1'b1, `MSTD_A_CMD, 32'h82);
      wait_start;
      chk_cnt(n, 5, "power-up gap");
      chk_val(slot, 32'h22, "on-chip slot");
      wait_idle;
      apb(1'b0, `MSTD_A_ALARM, 32'h0);
      chk_val(rd, 32'h10000, "low alarm");
      $display("test on-chip sensor done");
      wrap_up;
   end
endmodule // mstd_tb
